// ==== include/swsm_defines.svh ====
// constants of the single-wire slave memory block: opcodes, memory map and timing
`ifndef SWSM_DEFINES_SVH
`define SWSM_DEFINES_SVH

`define SWSM_CLK_MHZ 20

// net-address and function opcodes
`define SWSM_OP_SKIP 8'hcc
`define SWSM_OP_READ 8'h69
`define SWSM_OP_WRITE 8'h6c
`define SWSM_OP_COPY 8'h48
`define SWSM_OP_RECALL 8'hb8
`define SWSM_OP_LOCK 8'h6a

// memory map
`define SWSM_CTL_ADDR 8'h1f
`define SWSM_CTL_BUSY_BIT 7
`define SWSM_CTL_LOCKEN_BIT 6
`define SWSM_CTL_RESET 8'h00
`define SWSM_RAM_FIRST 8'h08
`define SWSM_RAM_LAST 8'h1e
`define SWSM_BLK0_FIRST 8'h20
`define SWSM_BLK0_LAST 8'h2f
`define SWSM_BLK1_FIRST 8'h60
`define SWSM_BLK1_LAST 8'h7f

// times in microseconds
`define SWSM_SAMPLE_STD_US 30
`define SWSM_SAMPLE_OD_US 4
`define SWSM_RESET_STD_US 120
`define SWSM_RESET_OD_US 16
`define SWSM_PDH_STD_US 30
`define SWSM_PDH_OD_US 3
`define SWSM_PDL_STD_US 120
`define SWSM_PDL_OD_US 12
`define SWSM_REL_STD_US 25
`define SWSM_REL_OD_US 3
`define SWSM_COPY_US 10000

// the same times as clock cycles
`define SWSM_SAMPLE_STD_CYC (`SWSM_SAMPLE_STD_US * `SWSM_CLK_MHZ)
`define SWSM_SAMPLE_OD_CYC (`SWSM_SAMPLE_OD_US * `SWSM_CLK_MHZ)
`define SWSM_RESET_STD_CYC (`SWSM_RESET_STD_US * `SWSM_CLK_MHZ)
`define SWSM_RESET_OD_CYC (`SWSM_RESET_OD_US * `SWSM_CLK_MHZ)
`define SWSM_PDH_STD_CYC (`SWSM_PDH_STD_US * `SWSM_CLK_MHZ)
`define SWSM_PDH_OD_CYC (`SWSM_PDH_OD_US * `SWSM_CLK_MHZ)
`define SWSM_PDL_STD_CYC (`SWSM_PDL_STD_US * `SWSM_CLK_MHZ)
`define SWSM_PDL_OD_CYC (`SWSM_PDL_OD_US * `SWSM_CLK_MHZ)
`define SWSM_REL_STD_CYC (`SWSM_REL_STD_US * `SWSM_CLK_MHZ)
`define SWSM_REL_OD_CYC (`SWSM_REL_OD_US * `SWSM_CLK_MHZ)
`define SWSM_COPY_CYC (`SWSM_COPY_US * `SWSM_CLK_MHZ)

`endif

// ==== include/swsm_pkg.sv ====
// types of the single-wire slave memory block
package swsm_pkg;

    // line-level sequencer states
    typedef enum logic [2:0] {L_IDLE, L_SLOT, L_RST, L_PDH, L_PDL} swsm_link_t;

    // byte-level protocol phases
    typedef enum logic [2:0] {P_ROM, P_FUNC, P_ADDR, P_READ, P_WRITE, P_IGNORE} swsm_phase_t;

    typedef struct packed {
        logic dq1;
        logic dq2;
        logic dq3;
        logic spd1;
        logic spd2;
        logic speed;
        swsm_link_t lstate;
        logic [11:0] cnt;
        logic drive;
        swsm_phase_t phase;
        logic [7:0] op;
        logic [7:0] sh;
        logic [2:0] bcnt;
        logic [7:0] addr;
        logic [7:0] tx;
        logic copy_pend;
        logic copy_blk;
        logic busy;
        logic [17:0] copy_cnt;
        logic lock_en;
        logic [1:0] locks;
        logic cur_set;
        logic prev_set;
    } swsm_state_t;

endpackage

// ==== design/swsm_slave.sv ====
// single-wire slave: reset/presence, bit slots and memory function commands
//
// Behaviour
// - after read opcode and address, first read slot gives LSB of that location.
// - read address increments after each byte, wrapping FFh to 00 until reset.
// - a reset pulse at any bit boundary abandons a read cleanly.
// - reserved locations may read back any value.
// - reads of nonvolatile block addresses return the shadow copy.
// - write opcode and address; each completed byte stored, then address increments.
// - writes past top address wrap to zero and overwrite from there.
// - writes to read-only, reserved, locked locations and partial bytes are dropped.
// - writes to unlocked nonvolatile blocks change only the shadow copy.
// - copy opcode programs the block's shadow into cells unless block locked or a copy is running.
// - during copy, busy flag is one and nonvolatile writes are ignored.
// - copy starts at first falling edge after address, lasts copy duration.
// - recall opcode loads block's cells into its shadow copy.
// - lock works only if previous transaction set lock-enable bit 6 of 1Fh.
// - locked blocks stay locked until RESETN_IN is asserted and refuse writes and copies.
// - after reset pulse rise, wait presence-high delay then drive presence low.
// - write slot sampled 15-60 us after fall (2-6 us overdrive).
// - device drives zero bits low in read slot, releases before slot end.
// - speed select low is standard, high overdrive; stable before reset.
// - line low beyond 120 us (16 us overdrive) is a reset; abort transaction.
`timescale 1ns/1ps
`include "swsm_defines.svh"

module swsm_slave #(
    parameter int unsigned COPY_CYCLES = `SWSM_COPY_CYC
) (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic DQ_IN,
    output logic DQ_OUT,
    output logic DQ_OE_OUT,
    input wire logic SPEED_SEL_IN,
    output logic COPY_BUSY_OUT
);
    import swsm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state, memories and per-cycle strobes
    swsm_state_t s_q;
    swsm_state_t s_d;
    logic [7:0] shadow [0:255];
    logic [7:0] cells [0:255];
    logic fall;
    logic bit_ev;
    logic bit_val;
    logic [7:0] sh_new;
    logic mem_we;
    logic [7:0] mem_wa;
    logic [7:0] mem_wd;
    logic do_copy;
    logic do_recall;
    logic blk_sel;
    logic [11:0] samp_c;
    logic [11:0] rst_c;
    logic [11:0] pdh_c;
    logic [11:0] pdl_c;
    logic [11:0] rel_c;
    logic [1:0] ainfo;
    logic [1:0] winfo;

    // returns {in a nonvolatile block, block index}
    function automatic logic [1:0] blk_info(input logic [7:0] a);
        if (a >= `SWSM_BLK0_FIRST && a <= `SWSM_BLK0_LAST)
            return 2'b10;
        else if (a >= `SWSM_BLK1_FIRST && a <= `SWSM_BLK1_LAST)
            return 2'b11;
        else
            return 2'b00;
    endfunction

    // byte seen by a read; the control register is assembled live
    function automatic logic [7:0] rd_byte(input logic [7:0] a, input swsm_state_t s);
        logic [7:0] v;
        v = shadow[a]; // nonvolatile addresses give the shadow, reserved gives stale data
        if (a == `SWSM_CTL_ADDR)
        begin
            v = `SWSM_CTL_RESET;
            v[`SWSM_CTL_BUSY_BIT] = s.busy;
            v[`SWSM_CTL_LOCKEN_BIT] = s.lock_en;
            v[1:0] = s.locks;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // open-drain line: only ever pull low
    assign DQ_OUT = 1'b0;
    assign DQ_OE_OUT = s_q.drive;
    assign COPY_BUSY_OUT = s_q.busy;

    // slot timing follows the speed latched at the last reset pulse
    always_comb
    begin
        if (s_q.speed)
        begin
            samp_c = 12'(`SWSM_SAMPLE_OD_CYC);
            rst_c = 12'(`SWSM_RESET_OD_CYC);
            pdh_c = 12'(`SWSM_PDH_OD_CYC);
            pdl_c = 12'(`SWSM_PDL_OD_CYC);
            rel_c = 12'(`SWSM_REL_OD_CYC);
        end
        else
        begin
            samp_c = 12'(`SWSM_SAMPLE_STD_CYC);
            rst_c = 12'(`SWSM_RESET_STD_CYC);
            pdh_c = 12'(`SWSM_PDH_STD_CYC);
            pdl_c = 12'(`SWSM_PDL_STD_CYC);
            rel_c = 12'(`SWSM_REL_STD_CYC);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic: line sequencer, copy timer, byte protocol
    always_comb
    begin
        s_d = s_q;
        bit_ev = 1'b0;
        bit_val = 1'b0;
        mem_we = 1'b0;
        mem_wa = s_q.addr;
        do_copy = 1'b0;
        do_recall = 1'b0;
        blk_sel = 1'b0;
        // pins pass two flops before anything looks at them
        s_d.dq1 = DQ_IN;
        s_d.dq2 = s_q.dq1;
        s_d.dq3 = s_q.dq2;
        s_d.spd1 = SPEED_SEL_IN;
        s_d.spd2 = s_q.spd1;
        fall = s_q.dq3 && !s_q.dq2;
        winfo = blk_info(s_q.addr); // block of the write address; bit 0 picks the lock bit
        sh_new = {bit_val, s_q.sh[7:1]};
        mem_wd = sh_new;
        ainfo = blk_info(sh_new);

        // copy timer; busy drops by itself after the copy duration
        if (s_q.busy)
        begin
            if (s_q.copy_cnt == 18'(COPY_CYCLES - 1))
                s_d.busy = 1'b0;
            else
                s_d.copy_cnt = s_q.copy_cnt + 18'h00001;
        end
        // a pending copy launches on the next falling edge, whatever slot it opens
        if (fall && s_q.copy_pend)
        begin
            s_d.copy_pend = 1'b0;
            if (!s_q.busy && !s_q.locks[s_q.copy_blk])
            begin
                do_copy = 1'b1;
                blk_sel = s_q.copy_blk;
                s_d.busy = 1'b1;
                s_d.copy_cnt = 18'h00000;
            end
        end

        // line sequencer
        case (s_q.lstate)
            L_IDLE:
            begin
                if (fall)
                begin
                    s_d.lstate = L_SLOT;
                    s_d.cnt = 12'h000;
                    s_d.drive = (s_q.phase == P_READ) && !s_q.tx[s_q.bcnt];
                end
            end
            L_SLOT:
            begin
                s_d.cnt = s_q.cnt + 12'h001;
                if (s_q.cnt == rel_c)
                    s_d.drive = 1'b0; // released well before the slot ends
                if (s_q.cnt == samp_c)
                begin
                    bit_ev = 1'b1;
                    bit_val = s_q.dq2;
                end
                if (s_q.cnt > samp_c && s_q.dq2)
                    s_d.lstate = L_IDLE;
                else if (s_q.cnt == rst_c)
                begin
                    // long low: drop whatever was going on
                    s_d.lstate = L_RST;
                    s_d.drive = 1'b0;
                    s_d.phase = P_ROM;
                    s_d.bcnt = 3'h0;
                    s_d.prev_set = s_q.cur_set;
                    s_d.cur_set = 1'b0;
                end
            end
            L_RST:
            begin
                if (s_q.dq2)
                begin
                    s_d.lstate = L_PDH;
                    s_d.cnt = 12'h000;
                    s_d.speed = s_q.spd2;
                end
            end
            L_PDH:
            begin
                s_d.cnt = s_q.cnt + 12'h001;
                if (s_q.cnt == pdh_c - 12'h001)
                begin
                    s_d.lstate = L_PDL;
                    s_d.cnt = 12'h000;
                    s_d.drive = 1'b1;
                end
            end
            L_PDL:
            begin
                s_d.cnt = s_q.cnt + 12'h001;
                if (s_q.cnt == pdl_c - 12'h001)
                begin
                    s_d.lstate = L_IDLE;
                    s_d.drive = 1'b0;
                end
            end
            default:
                s_d.lstate = L_IDLE;
        endcase

        // byte protocol, LSB first; only whole bytes take effect
        sh_new = {bit_val, s_q.sh[7:1]};
        mem_wd = sh_new;
        ainfo = blk_info(sh_new);
        if (bit_ev)
        begin
            s_d.sh = sh_new;
            s_d.bcnt = s_q.bcnt + 3'h1;
            if (s_q.bcnt == 3'h7)
            begin
                case (s_q.phase)
                    P_ROM:
                        s_d.phase = (sh_new == `SWSM_OP_SKIP) ? P_FUNC : P_IGNORE;
                    P_FUNC:
                    begin
                        s_d.op = sh_new;
                        if (sh_new == `SWSM_OP_READ || sh_new == `SWSM_OP_WRITE || sh_new == `SWSM_OP_COPY ||
                            sh_new == `SWSM_OP_RECALL || sh_new == `SWSM_OP_LOCK)
                            s_d.phase = P_ADDR;
                        else
                            s_d.phase = P_IGNORE;
                    end
                    P_ADDR:
                    begin
                        s_d.addr = sh_new;
                        s_d.phase = P_IGNORE; // later bits wait for a reset
                        if (s_q.op == `SWSM_OP_READ)
                        begin
                            s_d.phase = P_READ;
                            s_d.tx = rd_byte(sh_new, s_q);
                        end
                        else if (s_q.op == `SWSM_OP_WRITE)
                            s_d.phase = P_WRITE;
                        else if (s_q.op == `SWSM_OP_COPY && ainfo[1])
                        begin
                            s_d.copy_pend = 1'b1;
                            s_d.copy_blk = ainfo[0];
                        end
                        else if (s_q.op == `SWSM_OP_RECALL && ainfo[1] && !s_q.busy)
                        begin
                            do_recall = 1'b1;
                            blk_sel = ainfo[0];
                        end
                        else if (s_q.op == `SWSM_OP_LOCK && ainfo[1] && s_q.prev_set && s_q.lock_en)
                            s_d.locks[ainfo[0]] = 1'b1;
                    end
                    P_READ:
                    begin
                        s_d.addr = s_q.addr + 8'h01; // wraps to 00
                        s_d.tx = rd_byte(s_q.addr + 8'h01, s_q);
                    end
                    P_WRITE:
                    begin
                        s_d.addr = s_q.addr + 8'h01; // wraps to 00
                        if (s_q.addr == `SWSM_CTL_ADDR)
                        begin
                            s_d.lock_en = sh_new[`SWSM_CTL_LOCKEN_BIT];
                            s_d.cur_set = sh_new[`SWSM_CTL_LOCKEN_BIT];
                        end
                        else if (s_q.addr >= `SWSM_RAM_FIRST && s_q.addr <= `SWSM_RAM_LAST)
                            mem_we = 1'b1;
                        else if (winfo[1] && !s_q.busy && !s_q.locks[winfo[0]])
                            mem_we = 1'b1; // shadow only
                    end
                    default:
                        s_d.phase = P_IGNORE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            s_q <= '0;
            s_q.dq1 <= 1'b1;
            s_q.dq2 <= 1'b1;
            s_q.dq3 <= 1'b1;
            s_q.lstate <= L_IDLE;
            s_q.phase <= P_IGNORE;
        end
        else
            s_q <= s_d;
    end

    // memories carry no reset: their content is undefined until written or recalled
    always_ff @(posedge CLK_IN)
    begin
        if (mem_we)
            shadow[mem_wa] <= mem_wd;
        for (int i = 0; i < 256; i++)
        begin
            if (do_copy && blk_info(8'(i)) == {1'b1, blk_sel})
                cells[i] <= shadow[i];
            if (do_recall && blk_info(8'(i)) == {1'b1, blk_sel})
                shadow[i] <= cells[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    sequence pdh_done_s;
        s_q.lstate == L_PDH && s_q.cnt == pdh_c - 12'h001;
    endsequence
    sequence pdl_held_s;
        (s_q.lstate == L_PDL && DQ_OE_OUT) [*8];
    endsequence

    presence_pulse_a: assert property (pdh_done_s |=> pdl_held_s)
        else $error("presence pulse not driven after presence-high delay");
    reset_abort_a: assert property (s_q.lstate == L_SLOT && s_q.cnt == rst_c
        && !(s_q.cnt > samp_c && s_q.dq2) |=> s_q.lstate == L_RST && s_q.phase == P_ROM && !DQ_OE_OUT)
        else $error("long low did not abort the transaction");
    read_release_a: assert property (s_q.lstate == L_SLOT && s_q.cnt == rel_c |=> !DQ_OE_OUT)
        else $error("read bit not released in time");
    sample_point_a: assert property (bit_ev |-> s_q.lstate == L_SLOT && s_q.cnt == samp_c)
        else $error("bit sampled outside the sample point");
    // busy bit of the control byte goes out as a one, so the line is left alone
    busy_flag_a: assert property (fall && s_q.lstate == L_IDLE && s_q.phase == P_READ && s_q.busy
        && s_q.addr == `SWSM_CTL_ADDR && s_q.bcnt == 3'h7 |=> !DQ_OE_OUT)
        else $error("copy busy flag not shown");
    copy_start_a: assert property (fall && s_q.copy_pend && !s_q.busy && !s_q.locks[s_q.copy_blk]
        |=> s_q.busy && s_q.copy_cnt == 18'h00000)
        else $error("copy did not start on falling edge");
    read_incr_a: assert property (bit_ev && s_q.phase == P_READ && s_q.bcnt == 3'h7
        |=> s_q.addr == $past(s_q.addr) + 8'h01)
        else $error("read address did not advance");
    guarded_write_a: assert property (mem_we |-> !(winfo[1] && (s_q.busy || s_q.locks[winfo[0]])))
        else $error("write reached a locked or busy block");
    lock_keep_a: assert property (($past(s_q.locks) & ~s_q.locks) == 2'b00)
        else $error("a lock bit was cleared");
endmodule

// ==== verification/swsm_master.sv ====
// bus master model for the single-wire slave: reset pulses and time slots
`timescale 1ns/1ps
module swsm_master (
    input wire logic clk_in,
    input wire logic dq_in,
    input wire logic od_in,
    output logic pull_out
);
    initial pull_out = 1'b0;

    task automatic hold(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // reset pulse; presence must be low mid-window and gone by the end
    task automatic line_reset(input int low, output logic ok);
        pull_out <= 1'b1;
        hold(low);
        pull_out <= 1'b0;
        hold(od_in ? 100 : 1000);
        ok = !dq_in;
        hold(od_in ? 300 : 2600);
        ok = ok && dq_in;
    endtask

    // one slot: 1 us low opens it, a one releases at once, a zero holds the whole slot
    task automatic slot(input logic b, output logic v);
        pull_out <= 1'b1;
        hold(20);
        if (b)
            pull_out <= 1'b0;
        hold(od_in ? 20 : 280);
        v = dq_in; // read valid time from the slot start
        hold(od_in ? 60 : 1000);
        pull_out <= 1'b0;
        hold(od_in ? 10 : 100);
    endtask

    // bytes go out and come in least significant bit first
    task automatic tx_byte(input logic [7:0] d);
        logic v;
        for (int i = 0; i < 8; i++)
            slot(d[i], v);
    endtask

    task automatic rx_byte(output logic [7:0] d);
        for (int i = 0; i < 8; i++)
            slot(1'b1, d[i]);
    endtask
endmodule

// ==== verification/single_wire_slave_memory_commands_tb.sv ====
// self-checking bench of the single-wire slave with a memory model
`timescale 1ns/1ps
`include "swsm_defines.svh"
module single_wire_slave_memory_commands_tb;
    // short copy time so the busy window spans two transactions only
    localparam int COPY_CYC = 9000;
    localparam logic [7:0] SK = `SWSM_OP_SKIP;
    localparam logic [7:0] WR = `SWSM_OP_WRITE;
    localparam logic [7:0] RD = `SWSM_OP_READ;
    localparam logic [7:0] CP = `SWSM_OP_COPY;
    localparam logic [7:0] RC = `SWSM_OP_RECALL;
    localparam logic [7:0] LK = `SWSM_OP_LOCK;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic od = 1'b0;
    logic pull, oe, dout, busy;
    wire dq = (pull || (oe && !dout)) ? 1'b0 : 1'b1;
    logic [7:0] mem [256];
    logic [7:0] nv [256];
    logic [7:0] msk [256] = '{default: 8'h00};
    logic [7:0] nvm [256] = '{default: 8'h00};
    logic [1:0] lk = 2'b00;
    logic lken = 1'b0, lkm = 1'b1, arm = 1'b0, pend = 1'b0, mbusy = 1'b0;
    int n_errors = 0, compares = 0, n_cp = 0, n_cp_exp = 0, bcnt = 0;

    swsm_slave #(.COPY_CYCLES(COPY_CYC)) dut_u (.CLK_IN(clk), .RESETN_IN(rst_n), .DQ_IN(dq),
        .DQ_OUT(dout), .DQ_OE_OUT(oe), .SPEED_SEL_IN(od), .COPY_BUSY_OUT(busy));
    swsm_master m_u (.clk_in(clk), .dq_in(dq), .od_in(od), .pull_out(pull));

    initial forever #25 clk = ~clk;

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("compares %0d, errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    function automatic int blk(input logic [7:0] a);
        if (a >= `SWSM_BLK0_FIRST && a <= `SWSM_BLK0_LAST) return 0;
        if (a >= `SWSM_BLK1_FIRST && a <= `SWSM_BLK1_LAST) return 1;
        return -1;
    endfunction

    // model write: plain ram, lock-enable bit, unlocked shadow when no copy runs
    function automatic void mwrite(input logic [7:0] a, input logic [7:0] d);
        int b;
        b = blk(a);
        if (a == `SWSM_CTL_ADDR)
        begin
            lken = d[6];
            lkm = 1'b1;
            arm = d[6];
        end
        else if ((a >= `SWSM_RAM_FIRST && a <= `SWSM_RAM_LAST) || (b >= 0 && !lk[b] && !mbusy))
        begin
            mem[a] = d;
            msk[a] = 8'hff;
        end
    endfunction

    // reserved and read-only places carry no mask, so any value passes there
    task automatic cmp(input logic [7:0] a, input logic [7:0] d);
        if (a == `SWSM_CTL_ADDR)
        begin
            check(d & {1'b1, lkm, 6'h3c}, {mbusy, lken & lkm, 6'h00});
            check(d[1:0], lk);
        end
        else if (msk[a] != 8'h00)
            check(d & msk[a], mem[a] & msk[a]);
    endtask

    // every transaction opens with a reset pulse, so nothing follows copy, recall or lock
    task automatic start_tr(input logic [7:0] sel, input int low, output logic armed);
        logic ok;
        armed = arm && lken;
        arm = 1'b0;
        mbusy = mbusy || pend; // a running copy stays busy until wait_idle sees it end
        pend = 1'b0;
        m_u.line_reset(low, ok);
        check(ok, 1'b1);
        m_u.tx_byte(sel);
    endtask

    // selector, opcode, address, n whole bytes, then loose bits cut off by the next reset
    task automatic tr(input logic [7:0] sel, input logic [7:0] op, input logic [7:0] a, input int n,
        input int extra, input logic [7:0] c);
        logic armed, v, cp, rc;
        logic [7:0] d, ad;
        int b;
        start_tr(sel, od ? 360 : 2800, armed);
        m_u.tx_byte(op);
        m_u.tx_byte(a);
        b = blk(a);
        ad = a;
        for (int i = 0; i < n; i++)
        begin
            if (op == RD)
            begin
                m_u.rx_byte(d);
                cmp(ad, d);
            end
            else
            begin
                d = (ad == `SWSM_CTL_ADDR) ? c : 8'($urandom);
                m_u.tx_byte(d);
                if (sel == SK && op == WR)
                    mwrite(ad, d);
            end
            ad = ad + 8'h01;
        end
        repeat (extra) m_u.slot(1'($urandom), v);
        cp = sel == SK && b >= 0 && op == CP && !lk[b] && !mbusy;
        rc = sel == SK && b >= 0 && op == RC;
        foreach (nv[j])
            if (blk(8'(j)) == b && cp)
            begin
                nv[j] = mem[j];
                nvm[j] = msk[j];
            end
            else if (blk(8'(j)) == b && rc)
            begin
                mem[j] = nv[j];
                msk[j] = nvm[j];
            end
        if (cp)
        begin
            pend = 1'b1;
            n_cp_exp++;
        end
        if (sel == SK && b >= 0 && op == LK && armed)
        begin
            lk[b] = 1'b1;
            lkm = 1'b0;
        end
        check(busy, mbusy);
        $display("test op %0h at %0h done", op, a);
    endtask

    task automatic wait_idle;
        for (int i = 0; i < 2 * COPY_CYC && busy !== 1'b0; i++)
            @(posedge clk);
        mbusy = 1'b0;
        check(busy, 1'b0);
    endtask

    // busy width against the copy duration
    always @(posedge clk)
        if (busy === 1'b1)
            bcnt++;
        else if (bcnt != 0)
        begin
            check(bcnt, COPY_CYC);
            n_cp++;
            bcnt = 0;
        end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        logic ok;
        void'($urandom(18573));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        m_u.line_reset(2800, ok);
        check(ok, 1'b1);
        od <= 1'b1;
        @(posedge clk);
        m_u.line_reset(2800, ok);
        check(ok, 1'b1);
        $display("test speed switch done");
        tr(SK, WR, 8'h1d, 5, 0, 8'($urandom) & 8'hbf);
        tr(SK, RD, 8'h1d, 5, 0, 8'h00);
        tr(SK, WR, 8'hff, 10, 0, 8'h00);
        tr(8'h55, WR, 8'h08, 1, 0, 8'h00);
        tr(SK, RD, 8'hff, 10, 3, 8'h00);
        tr(SK, CP, 8'h20, 0, 0, 8'h00);
        tr(SK, RD, 8'h1f, 1, 0, 8'h00);
        tr(SK, WR, 8'h21, 1, 0, 8'h00);
        wait_idle;
        tr(SK, LK, 8'h20, 0, 0, 8'h00);
        tr(SK, WR, 8'h20, 1, 3, 8'h00);
        tr(SK, RD, 8'h1f, 3, 0, 8'h00);
        tr(SK, RC, 8'h20, 0, 0, 8'h00);
        tr(SK, WR, 8'h1f, 1, 0, 8'h40 | (8'($urandom) & 8'hbf));
        tr(SK, LK, 8'h20, 0, 0, 8'h00);
        tr(SK, WR, 8'h20, 1, 0, 8'h00);
        tr(SK, CP, 8'h20, 0, 0, 8'h00);
        tr(SK, RD, 8'h1f, 2, 0, 8'h00);
        check(n_cp, n_cp_exp);
        report_and_stop;
    end

    initial
    begin
        #5_750_000;
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        report_and_stop;
    end
endmodule
